/* File: dv/periph_model.sv */
// far-side model: 8-bit peripherals, program memory and timer count
module periph_model (
  // clock
  input  logic        sys_clk,
  // peripheral port
  input  logic [6:0]  per_addr,
  input  logic        per_we,
  input  logic        per_re,
  input  logic [7:0]  per_wdata,
  output logic [7:0]  per_rdata,
  // program memory
  input  logic        rom_re,
  input  logic [15:0] rom_addr,
  output logic [15:0] rom_data,
  // timer count value set by the bench
  input  logic [15:0] tmr_set,
  output logic [15:0] tmr_count
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ROM_KEY = 16'h5A3C;
  logic [7:0]  mem [0:7];
  logic [7:0]  rd_last_q;
  logic [15:0] rom_last_q;
  int          wr_cnt;
  // released lines show the inverse of the last value
  assign per_rdata = per_re ? mem[per_addr[2:0]] : ~rd_last_q;
  assign rom_data  = rom_re ? (rom_addr ^ ROM_KEY) : ~rom_last_q;
  assign tmr_count = tmr_set;
  initial begin
    rd_last_q  = 8'h00;
    rom_last_q = 16'h0000;
    wr_cnt     = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge sys_clk) begin
    if (per_we) begin
      mem[per_addr[2:0]] <= per_wdata;
      wr_cnt             <= wr_cnt + 1;
    end
    if (per_re) rd_last_q <= per_rdata;
    if (rom_re) rom_last_q <= rom_data;
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the transfer buffer block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import xfer_pkg::*;
  localparam int unsigned PW      = 10;
  localparam logic [15:0] ROM_KEY = 16'h5A3C;
  logic        sys_clk, arst_n, dm_req, dm_we, dm_hit_q, ins_valid;
  logic        ins_ready_q, ins_done_q, per_we_q, per_re_q, rom_re_q;
  logic [6:0]  dm_addr, ins_paddr, per_addr_q;
  logic [3:0]  dm_wdata, dm_rdata_q;
  logic [7:0]  per_wdata_q, per_rdata;
  logic [15:0] tmr_count, rom_addr_q, rom_data, tmr_set, w;
  xfer_op_e    ins_op;
  int          errors = 0;
  int          n_tests = 0;

  data_buffer_xfer #(.PTR_WIDTH(PW)) data_buffer_xfer_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .dm_req(dm_req), .dm_we(dm_we),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata_q(dm_rdata_q),
    .dm_hit_q(dm_hit_q), .ins_valid(ins_valid), .ins_op(ins_op),
    .ins_paddr(ins_paddr), .ins_ready_q(ins_ready_q),
    .ins_done_q(ins_done_q), .per_addr_q(per_addr_q), .per_we_q(per_we_q),
    .per_re_q(per_re_q), .per_wdata_q(per_wdata_q), .per_rdata(per_rdata),
    .tmr_count(tmr_count), .rom_re_q(rom_re_q), .rom_addr_q(rom_addr_q),
    .rom_data(rom_data));
  periph_model periph_model_inst (
    .sys_clk(sys_clk), .per_addr(per_addr_q), .per_we(per_we_q),
    .per_re(per_re_q), .per_wdata(per_wdata_q), .per_rdata(per_rdata),
    .rom_re(rom_re_q), .rom_addr(rom_addr_q), .rom_data(rom_data),
    .tmr_set(tmr_set), .tmr_count(tmr_count));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic dm_wr(logic [6:0] a, logic [3:0] d);
    dm_req = 1'b1;
    dm_we = 1'b1;
    dm_addr = a;
    dm_wdata = d;
    tick();
    dm_req = 1'b0;
    dm_we = 1'b0;
    tick();
  endtask
  task automatic dm_rd(logic [6:0] a, output logic [3:0] d,
                       output logic hit);
    dm_req = 1'b1;
    dm_we = 1'b0;
    dm_addr = a;
    tick();
    dm_req = 1'b0;
    d = dm_rdata_q;
    hit = dm_hit_q;
    tick();
  endtask
  task automatic set_buf(logic [15:0] v);
    for (int i = 0; i < 4; i++) dm_wr(7'h0C + 7'(i), v[15-4*i -: 4]);
  endtask
  task automatic get_buf(output logic [15:0] v);
    logic h;
    for (int i = 0; i < 4; i++) begin
      dm_rd(7'h0C + 7'(i), v[15-4*i -: 4], h);
      check("buffer hit", 16'(h), 16'h0001);
    end
  endtask
  task automatic instr(xfer_op_e op, logic [6:0] pa);
    int n;
    n = 0;
    while (ins_ready_q !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    ins_valid = 1'b1;
    ins_op = op;
    ins_paddr = pa;
    tick();
    ins_valid = 1'b0;
    check("ready busy", 16'(ins_ready_q), 16'h0000);
    n = 0;
    do begin
      n++;
      tick();
    end while (ins_done_q !== 1'b1 && n < 10);
    check("done latency", 16'(n + 1), 16'(XFER_CYCLES));
    tick();
    check("ready again", 16'(ins_ready_q), 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_layout;
    logic [3:0] d;
    logic       h;
    set_buf(16'h9C34);
    instr(OP_PUT, PA_SERIAL_SHIFT);
    check("serial byte", 16'(periph_model_inst.mem[1]), 16'h0034);
    dm_rd(7'h10, d, h);
    check("outside hit", 16'(h), 16'h0000);
    get_buf(w);
    check("buffer word", w, 16'h9C34);
  endtask
  task automatic t_put8;
    int c;
    for (int a = 1; a <= 4; a++) begin
      c = periph_model_inst.wr_cnt;
      set_buf({8'(a * 37), 8'hA0 + 8'(a)});
      instr(OP_PUT, 7'(a));
      check("put byte", 16'(periph_model_inst.mem[a]),
            16'h00A0 + 16'(a));
      check("put strobes", 16'(periph_model_inst.wr_cnt - c), 16'h0001);
    end
  endtask
  task automatic t_get8;
    for (int a = 1; a <= 4; a += 3) begin
      set_buf(16'h005A + 16'(a));
      instr(OP_PUT, 7'(a));
      set_buf(16'hC3E1);
      instr(OP_GET, 7'(a));
      get_buf(w);
      check("get word", w, 16'hC35A + 16'(a));
    end
  endtask
  task automatic t_refused;
    int c;
    c = periph_model_inst.wr_cnt;
    set_buf(16'h7E81);
    instr(OP_PUT, PA_TIMER_COUNT);
    instr(OP_NOP, PA_SERIAL_SHIFT);
    get_buf(w);
    check("ro put word", w, 16'h7E81);
    check("ro put strobes", 16'(periph_model_inst.wr_cnt - c), 16'h0000);
    instr(OP_GET, PA_TIMER1_MOD);
    get_buf(w);
    check("wo get upper", {w[15:8], 8'h00}, 16'h7E00);
  endtask
  task automatic t_pointer;
    set_buf(16'hFFFF);
    instr(OP_PUT, PA_POINTER);
    set_buf(16'h0000);
    instr(OP_GET, PA_POINTER);
    get_buf(w);
    check("pointer get", w, 16'h03FF);
    instr(OP_TABLE, PA_SERIAL_SHIFT);
    get_buf(w);
    check("table word", w, 16'h03FF ^ ROM_KEY);
    tmr_set = 16'hBEEF;
    instr(OP_GET, PA_TIMER_COUNT);
    get_buf(w);
    check("timer count", w, 16'hBEEF);
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    arst_n = 1'b0;
    dm_req = 1'b0;
    dm_we = 1'b0;
    dm_addr = 7'h00;
    dm_wdata = 4'h0;
    ins_valid = 1'b0;
    ins_op = OP_NOP;
    ins_paddr = 7'h00;
    tmr_set = 16'h0000;
    repeat (16) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    tick();
    t_layout();
    t_put8();
    t_get8();
    t_refused();
    t_pointer();
    end_of_test();
  end
  initial begin
    #(4000 * 50);
    errors++;
    end_of_test();
  end
endmodule

/* File: hw/data_buffer_xfer.sv */
// transfer buffer between cpu data memory, peripherals and program memory
module data_buffer_xfer #(
  parameter int unsigned PTR_WIDTH = xfer_pkg::PTR_WIDTH_DEF
) (
  // clock and reset
  input  logic              sys_clk,
  input  logic              arst_n,
  // data memory nibble access, bank zero
  input  logic              dm_req,
  input  logic              dm_we,
  input  logic [6:0]        dm_addr,
  input  logic [3:0]        dm_wdata,
  output logic [3:0]        dm_rdata_q,
  output logic              dm_hit_q,
  // transfer instruction
  input  logic              ins_valid,
  input  xfer_pkg::xfer_op_e ins_op,
  input  logic [6:0]        ins_paddr,
  output logic              ins_ready_q,
  output logic              ins_done_q,
  // 8-bit peripheral port
  output logic [6:0]        per_addr_q,
  output logic              per_we_q,
  output logic              per_re_q,
  output logic [7:0]        per_wdata_q,
  input  logic [7:0]        per_rdata,
  // combined timer count
  input  logic [15:0]       tmr_count,
  // program memory
  output logic              rom_re_q,
  output logic [15:0]       rom_addr_q,
  input  logic [15:0]       rom_data
);
  import xfer_pkg::*;

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  state_e      state_q;
  state_e      state_d;
  xfer_op_e    op_q;
  logic [6:0]  paddr_q;
  logic [15:0] ptr_value;
  logic        ptr_we;
  logic        taken;
  logic        in_xfer;
  logic        x_get;
  logic        x_put;
  logic        x_table;
  logic        x_is8;
  logic        x_ptr;
  logic        x_tmc;
  logic        issue_put_ext;
  logic        issue_get_ext;
  logic        issue_table;
  logic        dm_hit;
  logic [3:0]  dm_rdata_d;
  logic [6:0]  per_addr_d;
  logic [7:0]  per_wdata_d;
  logic [15:0] rom_addr_d;

  buf_bus_if bb ();

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic is_ext8(input logic [6:0] a);
    return a == PA_SERIAL_SHIFT || a == PA_TIMER0_MOD ||
           a == PA_TIMER1_MOD || a == PA_CONVERTER;
  endfunction

  function automatic logic is_ext_readable(input logic [6:0] a);
    return a == PA_SERIAL_SHIFT || a == PA_CONVERTER;
  endfunction

  function automatic logic [3:0] nib_lsb(input logic [1:0] sel);
    return {~sel, 2'b00};
  endfunction

  // ---------------------------------------------------------------------
  // storage and pointer register
  // ---------------------------------------------------------------------
  nibble_store u_store (
    .sys_clk (sys_clk),
    .bus     (bb)
  );

  pointer_reg #(
    .PTR_WIDTH (PTR_WIDTH)
  ) u_ptr (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .we      (ptr_we),
    .wdata   (bb.word),
    .value   (ptr_value)
  );

  // ---------------------------------------------------------------------
  // data memory decode
  // ---------------------------------------------------------------------
  assign dm_hit       = dm_req &&
                        dm_addr[6:2] == BUF_NIBBLE_TOP[6:2];
  assign bb.nib_we    = dm_hit && dm_we;
  assign bb.nib_sel   = dm_addr[1:0];
  assign bb.nib_wdata = dm_wdata;
  assign dm_rdata_d   = bb.word[nib_lsb(dm_addr[1:0]) +: 4];

  // ---------------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------------
  assign taken         = ins_valid && ins_ready_q;
  assign in_xfer       = state_q == ST_XFER;
  assign x_get         = in_xfer && op_q == OP_GET;
  assign x_put         = in_xfer && op_q == OP_PUT;
  assign x_table       = in_xfer && op_q == OP_TABLE;
  assign x_is8         = is_ext8(paddr_q);
  assign x_ptr         = paddr_q == PA_POINTER;
  assign x_tmc         = paddr_q == PA_TIMER_COUNT;
  assign issue_put_ext = taken && ins_op == OP_PUT &&
                         is_ext8(ins_paddr);
  assign issue_get_ext = taken && ins_op == OP_GET &&
                         is_ext_readable(ins_paddr);
  assign issue_table   = taken && ins_op == OP_TABLE;

  // ---------------------------------------------------------------------
  // buffer loads
  // ---------------------------------------------------------------------
  // write-only 8-bit targets still load whatever the port returns
  assign bb.ld_lo   = (x_get && (x_is8 || x_ptr || x_tmc)) ||
                      x_table;
  assign bb.ld_hi   = (x_get && (x_ptr || x_tmc)) || x_table;
  assign bb.ld_data = x_table ? rom_data :
                      x_ptr  ? ptr_value :
                      x_tmc  ? tmr_count :
                      {8'h00, per_rdata};
  // timer count never written: read-only target acts as no-op
  assign ptr_we     = x_put && x_ptr;

  // ---------------------------------------------------------------------
  // peripheral and rom request next values
  // ---------------------------------------------------------------------
  assign per_addr_d  = taken ? ins_paddr : per_addr_q;
  assign per_wdata_d = issue_put_ext ? bb.word[7:0] :
                       per_wdata_q;
  assign rom_addr_d  = issue_table ? ptr_value : rom_addr_q;

  // ---------------------------------------------------------------------
  // sequencer: fixed two cycles after acceptance for every op
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (taken) state_d = ST_XFER;
      ST_XFER: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NOP;
      paddr_q     <= PER_ADDR_RESET;
      ins_ready_q <= 1'b1;
      ins_done_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      op_q        <= taken ? ins_op : op_q;
      paddr_q     <= per_addr_d;
      ins_ready_q <= state_d == ST_IDLE;
      ins_done_q  <= state_d == ST_DONE;
    end
  end

  // ---------------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      per_addr_q  <= PER_ADDR_RESET;
      per_we_q    <= 1'b0;
      per_re_q    <= 1'b0;
      per_wdata_q <= PER_DATA_RESET;
      rom_re_q    <= 1'b0;
      rom_addr_q  <= PTR_RESET;
      dm_rdata_q  <= NIB_RESET;
      dm_hit_q    <= 1'b0;
    end else begin
      per_addr_q  <= per_addr_d;
      per_we_q    <= issue_put_ext;
      per_re_q    <= issue_get_ext;
      per_wdata_q <= per_wdata_d;
      rom_re_q    <= issue_table;
      rom_addr_q  <= rom_addr_d;
      dm_rdata_q  <= dm_hit && !dm_we ? dm_rdata_d : dm_rdata_q;
      dm_hit_q    <= dm_hit && !dm_we;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  done_fixed_a: assert property (
    taken |-> ##2 ins_done_q ##1 ins_ready_q)
    else $error("transfer did not finish in fixed cycles");

  put_send_a: assert property (
    issue_put_ext |=> per_we_q && per_addr_q == $past(ins_paddr))
    else $error("peripheral write not issued to selected address");

  put_low_a: assert property (
    taken && ins_op == OP_PUT && is_ext8(ins_paddr)
      |=> per_wdata_q == $past(bb.word[7:0]))
    else $error("peripheral write data not buffer low byte");

  put_ro_nop_a: assert property (
    taken && ins_op == OP_PUT && ins_paddr == PA_TIMER_COUNT
      |=> !per_we_q && !ptr_we ##1 $stable(ptr_value))
    else $error("write to read-only target changed state");

  get_low_a: assert property (
    x_get && x_is8 |=> bb.word[7:0] == $past(per_rdata))
    else $error("peripheral read data not loaded low");

  get8_keep_a: assert property (
    x_get && x_is8 && !bb.nib_we |=> $stable(bb.word[15:8]))
    else $error("8-bit read changed upper nibbles");

  get_ptr_zero_a: assert property (
    x_get && x_ptr |=> bb.word[15:PTR_WIDTH] == '0)
    else $error("pointer read above width not zero");

  table_load_a: assert property (
    issue_table |=> rom_re_q && rom_addr_q == $past(ptr_value)
      ##1 bb.word == $past(rom_data))
    else $error("table read did not load program word");

  dm_write_a: assert property (
    bb.nib_we && !in_xfer
      |=> bb.word[nib_lsb($past(dm_addr[1:0])) +: 4] == $past(dm_wdata))
    else $error("data memory write missed buffer nibble");

  rom_pulse_a: assert property (
    rom_re_q |=> !rom_re_q)
    else $error("program memory strobe longer than one cycle");

  ready_busy_a: assert property (
    taken |=> !ins_ready_q ##1 !ins_ready_q)
    else $error("request accepted while transfer busy");

  get_strobe_a: assert property (
    taken && ins_op == OP_GET && !is_ext_readable(ins_paddr)
      |=> !per_re_q)
    else $error("read strobe sent to write-only target");

  put_only_a: assert property (
    taken && !(ins_op == OP_PUT && is_ext8(ins_paddr)) |=> !per_we_q)
    else $error("write strobe without 8-bit peripheral write");

  tmr_get_a: assert property (
    x_get && x_tmc |=> bb.word == $past(tmr_count))
    else $error("timer count read not loaded whole");

  ptr_put_a: assert property (
    x_put && x_ptr
      |=> ptr_value[PTR_WIDTH-1:0] == $past(bb.word[PTR_WIDTH-1:0]))
    else $error("pointer write did not take low buffer bits");

  dm_low_a: assert property (
    dm_hit && !dm_we && dm_addr[1:0] == 2'h3
      |=> dm_hit_q && dm_rdata_q == $past(bb.word[3:0]))
    else $error("lowest nibble read not word bits 3 to 0");

  dm_high_a: assert property (
    dm_hit && !dm_we && dm_addr[1:0] == 2'h0
      |=> dm_hit_q && dm_rdata_q == $past(bb.word[15:12]))
    else $error("top nibble read not word bits 15 to 12");

  get_cover: cover property (taken && ins_op == OP_GET);
  put_cover: cover property (taken && ins_op == OP_PUT);
  table_cover: cover property (taken && ins_op == OP_TABLE);
  dm_cover: cover property (bb.nib_we ##1 dm_hit && !dm_we);
  ro_cover: cover property (taken && ins_op == OP_PUT &&
                            ins_paddr == PA_TIMER_COUNT);

endmodule

/* File: hw/nibble_store.sv */
// four-nibble transfer buffer storage, no reset
module nibble_store (
  // clock
  input logic sys_clk,
  // buffer carrier
  buf_bus_if.store bus
);
  import xfer_pkg::*;

  logic [3:0] nib_q [4];
  logic [3:0] nib_d [4];

  // ---------------------------------------------------------------------
  // lane j holds word bits 4j+3..4j; address 0FH is lane 0
  // ---------------------------------------------------------------------
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      nib_d[j] = nib_q[j];
      if ((j < 2) ? bus.ld_lo : bus.ld_hi) begin
        nib_d[j] = bus.ld_data[4*j +: 4];
      end else if (bus.nib_we && bus.nib_sel == 2'(3 - j)) begin
        nib_d[j] = bus.nib_wdata;
      end
    end
  end

  // undefined until first written
  always_ff @(posedge sys_clk) begin
    for (int j = 0; j < 4; j++) begin
      nib_q[j] <= nib_d[j];
    end
  end

  assign bus.word = {nib_q[3], nib_q[2], nib_q[1], nib_q[0]};

endmodule

/* File: hw/pointer_reg.sv */
// program pointer register with implemented width
module pointer_reg #(
  parameter int unsigned PTR_WIDTH = xfer_pkg::PTR_WIDTH_DEF
) (
  // clock and reset
  input  logic        sys_clk,
  input  logic        arst_n,
  // write from buffer
  input  logic        we,
  input  logic [15:0] wdata,
  // zero-extended value
  output logic [15:0] value
);
  import xfer_pkg::*;

  logic [PTR_WIDTH-1:0] ptr_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= PTR_RESET[PTR_WIDTH-1:0];
    end else if (we) begin
      ptr_q <= wdata[PTR_WIDTH-1:0];
    end
  end

  assign value = {{(16-PTR_WIDTH){1'b0}}, ptr_q};

endmodule

/* File: hw/xfer_pkg.sv */
// shared constants, types and the buffer carrier interface
package xfer_pkg;

  // ---------------------------------------------------------------------
  // data memory placement of the transfer buffer
  // ---------------------------------------------------------------------
  localparam int unsigned DM_ADDR_W            = 7;
  localparam logic [6:0]  BUF_NIBBLE_TOP       = 7'h0C;
  localparam logic [6:0]  BUF_NIBBLE_UPPER_MID = 7'h0D;
  localparam logic [6:0]  BUF_NIBBLE_LOWER_MID = 7'h0E;
  localparam logic [6:0]  BUF_NIBBLE_BOTTOM    = 7'h0F;
  localparam int unsigned BUF_W                = 16;
  localparam int unsigned NIB_W                = 4;
  localparam int unsigned LO_W                 = 8;

  // ---------------------------------------------------------------------
  // peripheral addresses
  // ---------------------------------------------------------------------
  localparam logic [6:0]  PA_SERIAL_SHIFT  = 7'h01;
  localparam logic [6:0]  PA_TIMER0_MOD    = 7'h02;
  localparam logic [6:0]  PA_TIMER1_MOD    = 7'h03;
  localparam logic [6:0]  PA_CONVERTER     = 7'h04;
  localparam logic [6:0]  PA_POINTER       = 7'h40;
  localparam logic [6:0]  PA_TIMER_COUNT   = 7'h45;

  // ---------------------------------------------------------------------
  // pointer register and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned PTR_WIDTH_DEF    = 12;
  localparam logic [15:0] PTR_RESET        = 16'h0000;
  localparam logic [6:0]  PER_ADDR_RESET   = 7'h00;
  localparam logic [7:0]  PER_DATA_RESET   = 8'h00;
  localparam logic [3:0]  NIB_RESET        = 4'h0;
  localparam int unsigned XFER_CYCLES      = 2;

  // ---------------------------------------------------------------------
  // instruction codes and sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_GET  = 2'b00,
    OP_PUT  = 2'b01,
    OP_TABLE = 2'b10,
    OP_NOP  = 2'b11
  } xfer_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_DONE = 2'b10
  } state_e;

endpackage

// carrier between the sequencer and the nibble storage
interface buf_bus_if;
  logic [15:0] word;
  logic        nib_we;
  logic [1:0]  nib_sel;
  logic [3:0]  nib_wdata;
  logic        ld_lo;
  logic        ld_hi;
  logic [15:0] ld_data;
  modport store (input nib_we, nib_sel, nib_wdata, ld_lo, ld_hi, ld_data,
                 output word);
  modport ctrl  (output nib_we, nib_sel, nib_wdata, ld_lo, ld_hi, ld_data,
                 input word);
endinterface
